//--- hdl/adc_ctrl_pkg.sv
/*
 Shared constants, codes and helpers for the converter select and
 power-down link: device end, controller end and their interface.
 Assumes a 125 MHz aclk on both ends.
*/
package adc_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // select debounce inside the converter
  localparam int DEB_TIME_NS = 40;
  localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // internal conversion time (least)
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // controller: select high time, quiet clock after select, half period
  localparam int CS_HIGH_NS = 200;
  localparam int CS_HIGH_CYCLES =
    (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_DIV = 8;

  localparam logic [3:0] CODE_STANDBY = 4'he;
  localparam logic [3:0] CODE_RESERVED = 4'hf;
  localparam logic [1:0] LEN_CODE_8 = 2'h1;
  localparam logic [1:0] LEN_CODE_16 = 2'h3;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_12 = 5'h0c;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] STANDBY_EDGE = 5'h04;
  localparam logic [4:0] LEN_EDGE = 5'h05;

  // controller register map (byte addresses)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RX = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [4:0] len_of(input logic [1:0] code);
    if (code == LEN_CODE_8) begin
      return LEN_8;
    end else if (code == LEN_CODE_16) begin
      return LEN_16;
    end
    return LEN_12;
  endfunction
endpackage

//--- hdl/adc_link_if.sv
/*
 Pin bundle between converter and controller, one modport per end.
 Assumes the result pin is pulled high while nobody drives it.
*/
`timescale 1ns/1ns
interface adc_link_if;
  logic cs_n;
  logic io_clk;
  logic serial_command_in;
  logic dout;
  logic dout_oe;
  logic eoc;
  logic data_line;

  // released line floats to the pull-up level
  assign data_line = dout_oe ? dout : 1'b1;

  modport dev (
    input cs_n, io_clk, serial_command_in,
    output dout, dout_oe, eoc
  );
  modport host (
    output cs_n, io_clk, serial_command_in,
    input data_line, eoc
  );
endinterface

//--- hdl/adc_dev_end.sv
/*
 Digital side of the converter: select debounce, command capture,
 serial result shift-out, conversion timing and power-down states.
 Assumes the link pins are asynchronous to aclk; the analog result
 arrives on conv_value and is sampled when the conversion ends.
*/
// Operation
// RULE1 - select high releases result pin at once
// RULE2 - debounced high select ignores shift clock
// RULE3 - debounced low select resets interface logic
// RULE4 - host keeps clock low after select
// RULE5 - select high aborts transfer or conversion
// RULE6 - early select keeps prior result buffered
// RULE7 - first bit appears when conversion-done rises
// RULE8 - host drops select before first cycle
// RULE9 - conversion start: done low, output low
// RULE10 - select falling edge presents first bit
// RULE11 - each clock falling edge shifts next bit
// RULE12 - standby code enters standby at edge four
// RULE13 - standby: no conversion, result kept
// RULE14 - interface active in standby, cycle completes
// RULE15 - power-on starts in standby
// RULE16 - only valid address leaves standby, converts
// RULE17 - auto power-down after conversion completes
// RULE18 - wake from auto power-down on select
// RULE19 - host normally holds select low
// RULE20 - length code picks 8, 12 or 16
// RULE21 - upper command nibble selects next conversion
// RULE22 - done high at reset, low at sampling end
// RULE23 - debounce counts cycles of synced select
`timescale 1ns/1ns
module adc_dev_end
  import adc_ctrl_pkg::*;
#(
  parameter int DEB_N = DEB_CYCLES,
  parameter int CONV_N = CONV_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  adc_link_if.dev link,
  // analog side
  input wire logic [11:0] conv_value,
  output logic [3:0] conv_channel,
  output logic conv_busy,
  output logic powered_down
);
  typedef enum logic [1:0] {m_standby, m_ready, m_convert} dev_mode_t;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic ck1;
    logic ck2;
    logic ck_prev;
    logic di1;
    logic di2;
    logic sel;
    logic [7:0] deb_cnt;
    dev_mode_t mode;
    logic auto_pd;
    logic [4:0] bit_cnt;
    logic [4:0] len;
    logic [7:0] cmd;
    logic [3:0] cfg;
    logic [3:0] chan;
    logic [15:0] buf_word;
    logic [15:0] out_sr;
    logic [15:0] conv_cnt;
    logic dout;
    logic dout_oe;
    logic eoc;
    logic busy;
    logic pdn;
  } dev_state_t;

  dev_state_t q, d;

  // result word with first bit at [15]; cfg is the low command nibble
  function automatic logic [15:0] build_word(input logic [11:0] v,
                                             input logic [3:0] cfg);
    logic [15:0] w;
    logic [15:0] r;
    logic [4:0] n;
    w = {v[11] ^ cfg[0], v[10:0], 4'h0};
    n = len_of(cfg[3:2]);
    if (n == LEN_8) begin
      w[7:0] = 8'h00;
    end
    r = w;
    if (cfg[1]) begin
      r = 16'h0000;
      for (int i = 0; i < 16; i++) begin
        if (i < int'(n)) begin
          r[15 - i] = w[16 - int'(n) + i];
        end
      end
    end
    return r;
  endfunction

  logic rise;
  logic fall;
  logic want;
  logic [15:0] done_word;

  always_comb begin
    d = q;
    rise = q.ck2 & ~q.ck_prev;
    fall = ~q.ck2 & q.ck_prev;
    want = ~q.cs2;
    done_word = build_word(conv_value, q.cfg);
    d.cs1 = link.cs_n;
    d.cs2 = q.cs1;
    d.ck1 = link.io_clk;
    d.ck2 = q.ck1;
    d.di1 = link.serial_command_in;
    d.di2 = q.di1;
    d.ck_prev = q.ck2;
    // synced level, no debounce, so release is as fast as sampling allows
    d.dout_oe = ~q.cs2; // see RULE1
    if (q.mode == m_convert) begin
      d.conv_cnt = q.conv_cnt + 16'h0001;
      if (q.conv_cnt == 16'(CONV_N - 1)) begin
        d.buf_word = done_word;
        d.mode = m_ready;
        d.eoc = 1'b1;
        d.auto_pd = 1'b1; // see RULE17
        if (q.sel) begin
          d.out_sr = done_word;
          d.dout = done_word[15]; // see RULE7
        end
      end
    end
    if (want == q.sel) begin
      d.deb_cnt = 8'h00;
    end else if (q.deb_cnt != 8'(DEB_N - 1)) begin
      d.deb_cnt = q.deb_cnt + 8'h01; // see RULE23
    end else begin
      d.deb_cnt = 8'h00;
      d.sel = want;
      d.bit_cnt = 5'h00;
      if (want) begin
        // fresh cycle: old result reloaded as first bit
        d.cmd = 8'h00; // see RULE3
        d.out_sr = q.buf_word;
        d.dout = q.buf_word[15]; // see RULE10
        d.auto_pd = 1'b0; // see RULE18
      end else if (q.mode == m_convert) begin
        // abort keeps buf_word untouched
        d.mode = m_ready; // see RULE5, RULE6
        d.eoc = 1'b1;
      end
    end
    // edges are dropped unless selected, see RULE2
    if (q.sel && want && q.mode != m_convert) begin
      if (rise) begin
        // only the first eight bits carry the command; later bits are fill
        if (q.bit_cnt < LEN_8) begin
          d.cmd = {q.cmd[6:0], q.di2};
        end
        d.bit_cnt = q.bit_cnt + 5'h01;
        d.auto_pd = 1'b0;
        if (q.bit_cnt == LEN_EDGE) begin
          d.len = len_of({q.cmd[0], q.di2}); // see RULE20
        end
      end else if (fall && q.bit_cnt != 5'h00) begin
        if (q.bit_cnt == STANDBY_EDGE && q.cmd[3:0] == CODE_STANDBY) begin
          d.mode = m_standby; // see RULE12
        end
        if (q.bit_cnt == q.len) begin
          d.bit_cnt = 5'h00;
          d.chan = q.cmd[7:4]; // see RULE21
          d.cfg = q.cmd[3:0];
          if (q.cmd[7:4] != CODE_STANDBY && q.cmd[7:4] != CODE_RESERVED) begin
            d.mode = m_convert; // see RULE16
            d.conv_cnt = 16'h0000;
            d.eoc = 1'b0; // see RULE22
            d.dout = 1'b0; // see RULE9
          end else begin
            // no conversion: the kept result is offered again, see RULE13
            d.out_sr = q.buf_word;
            d.dout = q.buf_word[15];
          end
        end else begin
          d.out_sr = {q.out_sr[14:0], 1'b0};
          d.dout = q.out_sr[14]; // see RULE11
        end
      end
    end
    // standby only ends through a valid address above, see RULE13, RULE14
    d.busy = d.mode == m_convert;
    d.pdn = d.mode == m_standby || d.auto_pd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.cs1 <= 1'b1;
      q.cs2 <= 1'b1;
      q.mode <= m_standby; // see RULE15
      q.pdn <= 1'b1;
      q.len <= LEN_12;
      q.eoc <= 1'b1; // see RULE22
    end else begin
      q <= d;
    end
  end

  assign link.dout = q.dout;
  assign link.dout_oe = q.dout_oe;
  assign link.eoc = q.eoc;
  assign conv_channel = q.chan;
  assign conv_busy = q.busy;
  assign powered_down = q.pdn;
endmodule

//--- hdl/adc_host_end.sv
/*
 Controller end: AXI4-Lite register slave that runs one serial cycle
 per command write, making the shift clock by dividing aclk.
 Assumes the converter answers on data_line and eoc asynchronously.
*/
`timescale 1ns/1ns
module adc_host_end
  import adc_ctrl_pkg::*;
#(
  parameter int HALF_N = HALF_DIV,
  parameter int CS_HIGH_N = CS_HIGH_CYCLES,
  parameter int SETTLE_N = SETTLE_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  adc_link_if.host link,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [2:0] {
    h_idle, h_cs_high, h_settle, h_wait, h_low, h_high
  } host_st_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] cmd;
    logic toggle;
    logic go;
    logic busy;
    logic [15:0] rx;
    host_st_t st;
    logic [7:0] cnt;
    logic [4:0] nbits;
    logic [4:0] idx;
    logic [7:0] sh;
    logic cs_n;
    logic sck;
    logic mosi;
    logic do1;
    logic do2;
    logic eo1;
    logic eo2;
  } host_state_t;

  host_state_t q, d;

  always_comb begin
    d = q;
    d.do1 = link.data_line;
    d.do2 = q.do1;
    d.eo1 = link.eoc;
    d.eo2 = q.eo1;
    // write: address and data in either order, answer after both
    if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
      d.aw_got = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.waddr == REG_CMD) begin
        // writes while busy are dropped but still answered
        if (q.wstrb0 && !q.busy && !q.go) begin
          d.cmd = q.wdata[7:0];
          d.go = 1'b1;
        end
      end else if (q.waddr == REG_CTRL) begin
        if (q.wstrb0) begin
          d.toggle = q.wdata[0];
        end
      end else if (q.waddr != REG_STATUS && q.waddr != REG_RX) begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_CMD: d.rdata[7:0] = q.cmd;
        REG_CTRL: d.rdata[0] = q.toggle;
        REG_STATUS: d.rdata[1:0] = {q.eo2, q.busy | q.go};
        REG_RX: d.rdata[15:0] = q.rx;
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    unique case (q.st)
      h_idle: begin
        if (q.go) begin
          d.go = 1'b0;
          d.busy = 1'b1;
          d.nbits = len_of(q.cmd[3:2]); // see RULE20
          d.sh = q.cmd;
          d.idx = 5'h00;
          d.cnt = 8'h00;
          d.rx = 16'h0000;
          // first cycle after reset always drops select, see RULE8
          if (q.toggle || q.cs_n) begin
            d.cs_n = 1'b1;
            d.st = h_cs_high; // see RULE19
          end else begin
            d.st = h_wait;
          end
        end
      end
      h_cs_high: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(CS_HIGH_N - 1)) begin
          d.cs_n = 1'b0;
          d.cnt = 8'h00;
          d.st = h_settle;
        end
      end
      h_settle: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(SETTLE_N - 1)) begin
          d.st = h_wait; // see RULE4
        end
      end
      h_wait: begin
        // result pin stays low while a conversion runs
        if (q.eo2) begin
          d.mosi = q.sh[7];
          d.cnt = 8'h00;
          d.st = h_low;
        end
      end
      h_low: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(HALF_N - 1)) begin
          d.sck = 1'b1;
          d.cnt = 8'h00;
          d.st = h_high;
        end
      end
      h_high: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'(HALF_N - 1)) begin
          // sampled late in the high phase, long after the bit settled
          d.rx = {q.rx[14:0], q.do2};
          d.sck = 1'b0;
          d.cnt = 8'h00;
          d.idx = q.idx + 5'h01;
          d.sh = {q.sh[6:0], 1'b0};
          d.mosi = q.sh[6];
          d.st = h_low;
          if (q.idx == q.nbits - 5'h01) begin
            d.busy = 1'b0; // see RULE14
            d.mosi = 1'b0;
            d.st = h_idle;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= h_idle;
      q.cs_n <= 1'b1;
      q.do1 <= 1'b1;
      q.do2 <= 1'b1;
      q.eo1 <= 1'b1;
      q.eo2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready = ~q.w_got & ~q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign link.cs_n = q.cs_n;
  assign link.io_clk = q.sck;
  assign link.serial_command_in = q.mosi;
endmodule

//--- tb/adc_link_monitor.sv
/*
 Checker on the converter/controller link pins.
 Assumes both ends use default timing and share one aclk.
*/
`timescale 1ns/1ns
module adc_link_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link pins
  input wire logic cs_n,
  input wire logic io_clk,
  input wire logic serial_command_in,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic eoc,
  input wire logic data_line
);
  // default conversion plus sync margin
  localparam int CONV_MAX = 262;
  logic [4:0] hi_q;
  logic [5:0] idle_q;
  logic [4:0] rise_q;
  logic clk_q;

  // a long quiet shift clock starts a new frame count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q <= 5'h00;
      idle_q <= 6'h00;
      rise_q <= 5'h00;
      clk_q <= 1'b0;
    end else begin
      clk_q <= io_clk;
      hi_q <= !cs_n ? 5'h00 : hi_q + {4'h0, hi_q != 5'h1f};
      idle_q <= io_clk ? 6'h00 : idle_q + {5'h0, idle_q != 6'h3f};
      if (idle_q == 6'h20) begin
        rise_q <= 5'h00;
      end else if (io_clk && !clk_q) begin
        rise_q <= rise_q + 5'h01;
      end
    end
  end

  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence conv_start;
    $fell(eoc);
  endsequence
  sequence conv_hold;
    !eoc [*8];
  endsequence

  release_on_high_a: assert property ($rose(cs_n) |-> ##[1:4] !dout_oe)
    else $error("result pin driven after deselect");
  clock_ignored_a: assert property (hi_q > 5'h0c |-> $stable(eoc) && !dout_oe)
    else $error("state moved while deselected");
  quiet_clock_a: assert property ($fell(cs_n) |-> !io_clk [*8])
    else $error("shift clock active right after select");
  first_drive_a: assert property ($fell(cs_n) |-> ##[1:4] dout_oe)
    else $error("first bit not driven after select");
  output_low_a: assert property (
    !eoc && !$past(eoc, 4) && dout_oe |-> !dout)
    else $error("result pin not low while converting");
  bit_hold_a: assert property (
    io_clk && $past(io_clk) && dout_oe && $past(dout_oe) |-> $stable(dout))
    else $error("result bit changed in clock high phase");
  conv_bound_a: assert property (
    conv_start |-> conv_hold ##[1:CONV_MAX] eoc)
    else $error("conversion length out of bounds");
  reset_done_a: assert property ($rose(aresetn) |-> eoc && !dout_oe)
    else $error("done low or pin driven after reset");
  frame_length_a: assert property (
    conv_start |-> rise_q inside {5'h08, 5'h0c, 5'h10})
    else $error("frame length not 8, 12 or 16 clocks");
endmodule

//--- tb/testbench.sv
/*
 Bench: both link ends joined, driven through AXI4-Lite and conv_value, judged on register reads, link pins and converter outputs.
 Assumes default parameters on both ends.
*/
`timescale 1ns/1ns
module testbench;
  import adc_ctrl_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [11:0] conv_value = 12'ha5c;
  logic [3:0] conv_channel;
  logic conv_busy, powered_down;
  int fail_count = 0, cmp_count = 0, cyc = 0;

  always #4 aclk = ~aclk;
  adc_link_if lnk();
  adc_dev_end u_adc_dev_end (
    .aclk(aclk), .aresetn(aresetn), .link(lnk), .conv_value(conv_value),
    .conv_channel(conv_channel), .conv_busy(conv_busy),
    .powered_down(powered_down)
  );
  adc_host_end u_adc_host_end (
    .aclk(aclk), .aresetn(aresetn), .link(lnk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  adc_link_monitor u_adc_link_monitor (
    .aclk(aclk), .aresetn(aresetn), .cs_n(lnk.cs_n), .io_clk(lnk.io_clk),
    .serial_command_in(lnk.serial_command_in), .dout(lnk.dout),
    .dout_oe(lnk.dout_oe), .eoc(lnk.eoc), .data_line(lnk.data_line)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_eoc(input logic lvl, input int lim);
    int n;
    n = 0;
    while (lnk.eoc !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, lnk.eoc}, {31'h0, lvl});
  endtask

  // poll until the host frame is over, then fetch the received bits
  task automatic collect;
    int n;
    n = 0;
    do begin
      rd_reg(REG_STATUS);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    chk({31'h0, rd[0]}, 32'h0);
    rd_reg(REG_RX);
  endtask

  task automatic io_cycle(input logic tog, input logic [7:0] cmd);
    wr(REG_CTRL, {31'h0, tog});
    wr(REG_CMD, {24'h0, cmd});
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    collect;
  endtask

  task automatic t_first;
    chk({29'h0, lnk.eoc, lnk.dout_oe, powered_down}, 32'h5);
    io_cycle(1'b0, 8'h0c);
    wait_eoc(1'b0, 60);
    chk({30'h0, conv_busy, powered_down}, 32'h2);
    wait_eoc(1'b1, 400);
    repeat (16) @(posedge aclk);
    chk({31'h0, powered_down}, 32'h1);
    chk({28'h0, conv_channel}, 32'h0);
    $display("test first conversion done");
  endtask

  task automatic t_lengths;
    io_cycle(1'b0, 8'h1c);
    chk(rd, 32'ha5c0);
    wait_eoc(1'b0, 60);
    wait_eoc(1'b1, 400);
    chk({28'h0, conv_channel}, 32'h1);
    io_cycle(1'b1, 8'h24);
    chk(rd, 32'ha5);
    wait_eoc(1'b0, 60);
    wait_eoc(1'b1, 400);
    $display("test lengths done");
  endtask

  task automatic t_standby;
    conv_value <= 12'h3c1;
    io_cycle(1'b0, 8'he4);
    chk(rd, 32'ha5);
    repeat (300) @(posedge aclk);
    chk({29'h0, lnk.eoc, conv_busy, powered_down}, 32'h5);
    $display("test standby done");
  endtask

  task automatic t_abort;
    int n;
    io_cycle(1'b0, 8'h34);
    chk(rd, 32'ha5);
    wait_eoc(1'b0, 60);
    wr(REG_CTRL, 32'h1);
    wr(REG_CMD, 32'h44);
    n = 0;
    while (lnk.eoc !== 1'b1 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, n < 100}, 32'h1);
    collect;
    chk(rd, 32'ha5);
    wait_eoc(1'b0, 60);
    wait_eoc(1'b1, 400);
    chk({28'h0, conv_channel}, 32'h4);
    io_cycle(1'b0, 8'h04);
    chk(rd, 32'h3c);
    chk({28'h0, conv_channel}, 32'h0);
    rd_reg(4'h2);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("test abort done");
  endtask

  // bipolar result, low bit first, 8-bit length
  task automatic t_format;
    wait_eoc(1'b1, 400);
    io_cycle(1'b0, 8'h07);
    chk(rd, 32'h3c);
    wait_eoc(1'b0, 60);
    wait_eoc(1'b1, 400);
    io_cycle(1'b0, 8'h04);
    // bipolar top byte 0xbc, sent low bit first
    chk(rd, 32'h3d);
    $display("test format done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_first;
    t_lengths;
    t_standby;
    t_abort;
    t_format;
    tally_and_finish;
  end
endmodule
